// *** hdl/vdl_pkg.sv ***
// Shared constants and types for the video level control block
package vdl_pkg;

    // ****************************************
    // Widths
    // ****************************************
    localparam int unsigned CODE_W   = 8;
    localparam int unsigned APB_AW   = 12;
    localparam int unsigned APB_DW   = 32;
    localparam int unsigned CNT_W    = 16;
    localparam int unsigned BUF_DEPTH = 2;

    // ****************************************
    // Rates
    // ****************************************
    localparam int unsigned CLK_RATE_MHZ     = 100;
    localparam int unsigned PIX_RATE_MAX_MHZ = 75;
    // Least clock cycles between two accepted samples at the fastest pixel rate
    localparam int unsigned PIX_MIN_CYC =
        (CLK_RATE_MHZ + PIX_RATE_MAX_MHZ - 1) / PIX_RATE_MAX_MHZ;

    // ****************************************
    // Register offsets (byte addresses)
    // ****************************************
    localparam logic [APB_AW-1:0] OFS_CTRL   = 12'h000;
    localparam logic [APB_AW-1:0] OFS_STATUS = 12'h004;
    localparam logic [APB_AW-1:0] OFS_ACCEPT = 12'h008;
    localparam logic [APB_AW-1:0] OFS_STALL  = 12'h00C;

    // ****************************************
    // Control and status fields and reset values
    // ****************************************
    localparam int unsigned CTRL_EN_BIT  = 0;
    localparam int unsigned CTRL_PED_LSB = 1;
    localparam int unsigned CTRL_CLR_BIT = 3;
    localparam int unsigned STAT_S1_BIT   = 0;
    localparam int unsigned STAT_FULL_BIT = 1;
    localparam int unsigned STAT_OUTV_BIT = 2;
    localparam logic        CTRL_EN_RST  = 1'b1;

    // ****************************************
    // Codes
    // ****************************************
    localparam logic [CODE_W-1:0] CODE_WHITE = 8'hFF;
    localparam logic [CODE_W-1:0] CODE_ZERO  = 8'h00;

    // Static pedestal between black and blanking
    typedef enum logic [1:0] {
        PED_10_IRE = 2'b00,
        PED_7_IRE  = 2'b01,
        PED_0_IRE  = 2'b10
    } vdl_ped_e;
    localparam vdl_ped_e CTRL_PED_RST = PED_7_IRE;

    // Output level selection handed to the analog stage
    typedef enum logic [1:0] {
        LVL_ZERO      = 2'b00,
        LVL_BLANK     = 2'b01,
        LVL_DATA_SYNC = 2'b10,
        LVL_DATA      = 2'b11
    } vdl_level_e;

    // One resolved sample as it travels through the buffer
    typedef struct packed {
        logic [CODE_W-1:0] code;
        vdl_level_e        level;
        logic              boost;
    } vdl_sample_s;

    localparam int unsigned SAMPLE_W = $bits(vdl_sample_s);

endpackage

// *** hdl/vdl_buf.sv ***
// Small FIFO with valid/ready on both sides and read data muxed straight from the storage registers
module vdl_buf #(
    parameter int unsigned W     = 8,
    parameter int unsigned DEPTH = 2
) (
    // Clock and reset
    input  wire logic         clk_sys_i,
    input  wire logic         rstn_i,
    // Fill side
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    input  wire logic [W-1:0] in_data_i,
    // Drain side
    output logic              out_valid_o,
    input  wire logic         out_ready_i,
    output logic [W-1:0]      out_data_o
);

    localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    initial begin
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || W < 1) begin
            $error("vdl_buf: DEPTH must be a power of two of at least 2");
        end
    end

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [PW-1:0]           wr;
        logic [PW-1:0]           rd;
        logic [PW:0]             cnt;
    } vdl_buf_s;

    vdl_buf_s st;
    vdl_buf_s next_st;
    logic     push;
    logic     pop;

    assign in_ready_o  = (st.cnt != DEPTH[PW:0]);
    assign out_valid_o = (st.cnt != '0);
    assign out_data_o  = st.mem[st.rd];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    always_comb begin
        next_st = st;
        if (push) begin
            next_st.mem[st.wr] = in_data_i;
            next_st.wr         = st.wr + 1'b1;
        end
        if (pop) begin
            next_st.rd = st.rd + 1'b1;
        end
        case ({push, pop})
            2'b10:   next_st.cnt = st.cnt + 1'b1;
            2'b01:   next_st.cnt = st.cnt - 1'b1;
            default: next_st.cnt = st.cnt;
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

endmodule

// *** hdl/vdl_level_ctrl.sv ***
// Pixel and control capture, level resolution and APB registers of the video converter
//
// The APB slave port and the address map were left to the implementer.
module vdl_level_ctrl #(
    parameter int unsigned BUF_DEPTH = vdl_pkg::BUF_DEPTH
) (
    // Clock and reset
    input  wire logic                        clk_sys_i,
    input  wire logic                        rstn_i,
    // APB slave
    input  wire logic                        psel_i,
    input  wire logic                        penable_i,
    input  wire logic                        pwrite_i,
    input  wire logic [vdl_pkg::APB_AW-1:0]  paddr_i,
    input  wire logic [vdl_pkg::APB_DW-1:0]  pwdata_i,
    output logic      [vdl_pkg::APB_DW-1:0]  prdata_o,
    output logic                             pready_o,
    output logic                             pslverr_o,
    // Pixel input stream
    input  wire logic                        pix_valid_i,
    output logic                             pix_ready_o,
    input  wire logic [vdl_pkg::CODE_W-1:0]  pixel_code_i,
    input  wire logic                        blank_n_i,
    input  wire logic                        sync_n_i,
    input  wire logic                        ref_white_n_i,
    input  wire logic                        boost_n_i,
    // Converter side
    output logic                             dac_valid_o,
    input  wire logic                        dac_ready_i,
    output logic      [vdl_pkg::CODE_W-1:0]  dac_code_o,
    output vdl_pkg::vdl_level_e              dac_level_o,
    output logic                             dac_boost_o,
    output vdl_pkg::vdl_ped_e                pedestal_o
);

    import vdl_pkg::*;

    initial begin
        if (BUF_DEPTH < 2) begin
            $error("vdl_level_ctrl: BUF_DEPTH below 2 cannot absorb a stall");
        end
    end

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic              s1_valid;
        logic [CODE_W-1:0] s1_code;
        logic              s1_blank_n;
        logic              s1_sync_n;
        logic              s1_white_n;
        logic              s1_boost_n;
        logic              ctrl_en;
        vdl_ped_e          ctrl_ped;
        logic [APB_DW-1:0] rdata;
        logic              slverr;
        logic [CNT_W-1:0]  acc_cnt;
        logic [CNT_W-1:0]  stall_cnt;
    } vdl_state_s;

    vdl_state_s  st;
    vdl_state_s  next_st;
    vdl_sample_s res;
    vdl_sample_s buf_out;
    logic        buf_in_ready;
    logic        take;
    logic        setup_ph;
    logic        access_ph;
    logic        wr_ctrl;
    logic        clr_cnt;

    // ****************************************
    // Level resolution
    // ****************************************
    function automatic vdl_sample_s resolve(
        input logic [CODE_W-1:0] code,
        input logic              blank_n,
        input logic              sync_n,
        input logic              white_n,
        input logic              boost_n,
        input logic              en
    );
        vdl_sample_s s;
        s.code  = code;
        s.level = LVL_DATA;
        s.boost = 1'b0;
        if (!blank_n || !en) begin
            // Data, white and boost ignored while blanking
            s.code  = CODE_ZERO;
            s.level = sync_n ? LVL_BLANK : LVL_ZERO;
        end else begin
            if (!white_n) begin
                s.code = CODE_WHITE;
            end
            s.level = sync_n ? LVL_DATA : LVL_DATA_SYNC;
            s.boost = !boost_n;
        end
        return s;
    endfunction

    assign res = resolve(st.s1_code, st.s1_blank_n, st.s1_sync_n,
                         st.s1_white_n, st.s1_boost_n, st.ctrl_en);

    // ****************************************
    // Input stage
    // ****************************************
    // Stage advances whenever the buffer can take the resolved sample
    assign pix_ready_o = !st.s1_valid || buf_in_ready;
    assign take        = pix_valid_i && pix_ready_o;

    // ****************************************
    // APB decode
    // ****************************************
    assign setup_ph  = psel_i && !penable_i;
    assign access_ph = psel_i && penable_i;
    assign pready_o  = 1'b1;
    assign prdata_o  = st.rdata;
    assign pslverr_o = st.slverr;
    assign wr_ctrl   = access_ph && pwrite_i && (paddr_i == OFS_CTRL);
    assign clr_cnt   = wr_ctrl && pwdata_i[CTRL_CLR_BIT];

    function automatic logic addr_mapped(input logic [APB_AW-1:0] a);
        return (a == OFS_CTRL) || (a == OFS_STATUS) ||
               (a == OFS_ACCEPT) || (a == OFS_STALL);
    endfunction

    always_comb begin
        next_st = st;

        // Pixel and controls captured together
        if (take) begin
            next_st.s1_code    = pixel_code_i;
            next_st.s1_blank_n = blank_n_i;
            next_st.s1_sync_n  = sync_n_i;
            next_st.s1_white_n = ref_white_n_i;
            next_st.s1_boost_n = boost_n_i;
        end
        if (pix_ready_o) begin
            next_st.s1_valid = take;
        end

        // Activity counters saturate
        if (clr_cnt) begin
            next_st.acc_cnt   = '0;
            next_st.stall_cnt = '0;
        end else begin
            if (take && st.acc_cnt != '1) begin
                next_st.acc_cnt = st.acc_cnt + 1'b1;
            end
            if (pix_valid_i && !pix_ready_o && st.stall_cnt != '1) begin
                next_st.stall_cnt = st.stall_cnt + 1'b1;
            end
        end

        // Read data and error prepared in the setup phase
        if (setup_ph) begin
            next_st.rdata  = '0;
            next_st.slverr = !addr_mapped(paddr_i);
            if (!pwrite_i) begin
                case (paddr_i)
                    OFS_CTRL: begin
                        next_st.rdata[CTRL_EN_BIT]                = st.ctrl_en;
                        next_st.rdata[CTRL_PED_LSB +: 2]          = st.ctrl_ped;
                    end
                    OFS_STATUS: begin
                        next_st.rdata[STAT_S1_BIT]   = st.s1_valid;
                        next_st.rdata[STAT_FULL_BIT] = !buf_in_ready;
                        next_st.rdata[STAT_OUTV_BIT] = dac_valid_o;
                    end
                    OFS_ACCEPT: begin
                        next_st.rdata[CNT_W-1:0] = st.acc_cnt;
                    end
                    OFS_STALL: begin
                        next_st.rdata[CNT_W-1:0] = st.stall_cnt;
                    end
                    default: begin
                        next_st.rdata = '0;
                    end
                endcase
            end
        end

        // Control write takes effect at the access edge
        if (wr_ctrl) begin
            next_st.ctrl_en = pwdata_i[CTRL_EN_BIT];
            case (pwdata_i[CTRL_PED_LSB +: 2])
                PED_10_IRE: next_st.ctrl_ped = PED_10_IRE;
                PED_7_IRE:  next_st.ctrl_ped = PED_7_IRE;
                PED_0_IRE:  next_st.ctrl_ped = PED_0_IRE;
                default:    next_st.ctrl_ped = st.ctrl_ped;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st            <= '0;
            st.s1_blank_n <= 1'b0;
            st.s1_sync_n  <= 1'b1;
            st.s1_white_n <= 1'b1;
            st.s1_boost_n <= 1'b1;
            st.ctrl_en    <= CTRL_EN_RST;
            st.ctrl_ped   <= CTRL_PED_RST;
        end else begin
            st <= next_st;
        end
    end

    // ****************************************
    // Output buffer
    // ****************************************
    // Stalls on the converter side back up into the input stage
    vdl_buf #(
        .W     (SAMPLE_W),
        .DEPTH (BUF_DEPTH)
    ) u_buf (
        .clk_sys_i   (clk_sys_i),
        .rstn_i      (rstn_i),
        .in_valid_i  (st.s1_valid),
        .in_ready_o  (buf_in_ready),
        .in_data_i   (res),
        .out_valid_o (dac_valid_o),
        .out_ready_i (dac_ready_i),
        .out_data_o  (buf_out)
    );

    // Code, level and boost leave the same buffer register; the pedestal comes straight from the control register
    assign dac_code_o  = buf_out.code;
    assign dac_level_o = buf_out.level;
    assign dac_boost_o = buf_out.boost;
    assign pedestal_o  = st.ctrl_ped;

endmodule

// *** bench/vdl_level_ctrl_asserts.sv ***
// Port checker of the video level control block
module vdl_level_ctrl_asserts
    import vdl_pkg::*;
#(
    parameter int unsigned BUF_DEPTH = 2
) (
    // Clock and APB
    input wire logic clk_sys_i, rstn_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o,
    input wire logic [APB_AW-1:0] paddr_i,
    input wire logic [APB_DW-1:0] pwdata_i, prdata_o,
    // Pixel stream
    input wire logic pix_valid_i, pix_ready_o, blank_n_i, sync_n_i, ref_white_n_i, boost_n_i,
    input wire logic [CODE_W-1:0] pixel_code_i, dac_code_o,
    // Converter side
    input wire logic dac_valid_o, dac_ready_i, dac_boost_o,
    input wire vdl_level_e dac_level_o,
    input wire vdl_ped_e pedestal_o
);
    logic prev_v;
    logic fresh;
    default clocking @(posedge clk_sys_i);
    endclocking
    default disable iff (!rstn_i);
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) prev_v <= 1'b0;
        else prev_v <= pix_valid_i;
    end
    // Sample taken into an empty pipeline
    assign fresh = pix_valid_i && !prev_v && !dac_valid_o;
    a_blank_code: assert property (
        dac_valid_o && dac_level_o inside {LVL_BLANK, LVL_ZERO}
        |-> dac_code_o == CODE_ZERO && !dac_boost_o) else $error("blank sample carries data");
    a_take_lat: assert property (
        pix_valid_i && pix_ready_o |-> ##2 dac_valid_o) else $error("sample late at output");
    a_stall_hold: assert property (
        dac_valid_o && !dac_ready_i |=> dac_valid_o && $stable(dac_code_o)
        && $stable(dac_level_o) && $stable(dac_boost_o)) else $error("output moved in stall");
    a_ready_empty: assert property (
        !dac_valid_o |-> pix_ready_o) else $error("refused with empty buffer");
    a_ped_static: assert property (
        !(psel_i && penable_i && pwrite_i) |=> $stable(pedestal_o)) else $error("pedestal moved");
    a_blank_sel: assert property (
        fresh && !blank_n_i && sync_n_i |-> ##2 dac_level_o == LVL_BLANK)
        else $error("blank level missing");
    a_white_sel: assert property (
        fresh && blank_n_i && sync_n_i && !ref_white_n_i
        |-> ##2 (dac_code_o == CODE_WHITE) != (dac_level_o == LVL_BLANK))
        else $error("white force missing");
    a_dsync_sel: assert property (
        fresh && blank_n_i && !sync_n_i |-> ##2 dac_level_o inside {LVL_DATA_SYNC, LVL_ZERO})
        else $error("data minus sync missing");
endmodule

bind vdl_level_ctrl vdl_level_ctrl_asserts #(.BUF_DEPTH(BUF_DEPTH)) u_chk (
    .clk_sys_i, .rstn_i, .psel_i, .penable_i, .pwrite_i, .pready_o, .pslverr_o, .paddr_i,
    .pwdata_i, .prdata_o, .pix_valid_i, .pix_ready_o, .blank_n_i, .sync_n_i, .ref_white_n_i,
    .boost_n_i, .pixel_code_i, .dac_code_o, .dac_valid_o, .dac_ready_i, .dac_boost_o,
    .dac_level_o, .pedestal_o
);

// *** bench/vdl_pix_src.sv ***
// Pixel source model driving the block's input stream
module vdl_pix_src (
    // Clock and handshake
    input  wire logic  clk_sys_i,
    input  wire logic  pix_ready_i,
    output logic       pix_valid_o,
    // Sample
    output logic [7:0] pixel_code_o,
    output logic       blank_n_o,
    output logic       sync_n_o,
    output logic       ref_white_n_o,
    output logic       boost_n_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        pix_valid_o = 1'b0;
        pixel_code_o = 8'h00;
        {blank_n_o, sync_n_o, ref_white_n_o, boost_n_o} = 4'hF;
    end
    task automatic send(input logic [7:0] c, input logic [3:0] k, output bit ok);
        int n;
        @(posedge clk_sys_i);
        pix_valid_o <= 1'b1;
        pixel_code_o <= c;
        {blank_n_o, sync_n_o, ref_white_n_o, boost_n_o} <= k;
        ok = 1'b0;
        for (n = 0; n < 50 && !ok; n++) begin
            @(posedge clk_sys_i);
            ok = (pix_ready_i === 1'b1);
        end
        // Released lines show the inverse, not stale data
        pix_valid_o <= 1'b0;
        pixel_code_o <= ~c;
        {blank_n_o, sync_n_o, ref_white_n_o, boost_n_o} <= ~k;
    endtask
endmodule

// *** bench/vdl_level_ctrl_tb.sv ***
// Self-checking bench of the video level control block
module vdl_level_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import vdl_pkg::*;
    logic clk_sys_i = 0, rstn_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0, dac_ready_i = 1;
    logic [11:0] paddr_i = 0;
    logic [31:0] pwdata_i = 0, prdata_o, rd;
    logic pready_o, pslverr_o, pix_valid_i, pix_ready_o, dac_valid_o, dac_boost_o, er;
    logic blank_n_i, sync_n_i, ref_white_n_i, boost_n_i, en = 1;
    logic [7:0] pixel_code_i, dac_code_o;
    vdl_level_e dac_level_o;
    vdl_ped_e pedestal_o;
    vdl_sample_s got_q[$], exp_q[$];
    int num_errors = 0, check_count = 0, i;
    bit ok;

    vdl_level_ctrl dut (.clk_sys_i, .rstn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
        .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .pix_valid_i, .pix_ready_o,
        .pixel_code_i, .blank_n_i, .sync_n_i, .ref_white_n_i, .boost_n_i, .dac_valid_o,
        .dac_ready_i, .dac_code_o, .dac_level_o, .dac_boost_o, .pedestal_o);
    vdl_pix_src u_src (.clk_sys_i, .pix_ready_i(pix_ready_o), .pix_valid_o(pix_valid_i),
        .pixel_code_o(pixel_code_i), .blank_n_o(blank_n_i), .sync_n_o(sync_n_i),
        .ref_white_n_o(ref_white_n_i), .boost_n_o(boost_n_i));

    initial begin
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    always @(posedge clk_sys_i) begin
        if (rstn_i && dac_valid_o === 1'b1 && dac_ready_i === 1'b1) begin
            got_q.push_back({dac_code_o, dac_level_o, dac_boost_o});
        end
    end

    // ****************************************
    // Tasks
    // ****************************************
    task automatic finish_test();
        $display("errors %0d checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic hang();
        num_errors++;
        $display("[ERR] %0t wait timed out", $time);
        finish_test();
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_sys_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_sys_i);
        penable_i <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge clk_sys_i);
            if (pready_o === 1'b1) break;
        end
        if (n == 20) hang();
        rd = prdata_o;
        er = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    function automatic vdl_sample_s res(input logic [7:0] c, input logic [3:0] k);
        if (!k[3] || !en) return '{CODE_ZERO, k[2] ? LVL_BLANK : LVL_ZERO, 1'b0};
        return '{k[1] ? c : CODE_WHITE, k[2] ? LVL_DATA : LVL_DATA_SYNC, !k[0]};
    endfunction
    task automatic px(input logic [7:0] c, input logic [3:0] k);
        exp_q.push_back(res(c, k));
        u_src.send(c, k, ok);
        if (!ok) hang();
    endtask
    task automatic drain();
        int n;
        for (n = 0; n < 100; n++) begin
            if (got_q.size() >= exp_q.size()) break;
            @(posedge clk_sys_i);
        end
        if (n == 100) hang();
        while (exp_q.size() > 0) chk(got_q.pop_front(), exp_q.pop_front());
        chk(got_q.size(), 0);
    endtask

    // ****************************************
    // Sequence
    // ****************************************
    initial begin
        repeat (12) @(posedge clk_sys_i);
        rstn_i <= 1'b1;
        apb(0, OFS_CTRL, 0);
        chk(rd, 32'h0000_0003);
        apb(0, 12'h010, 0);
        chk({rd[30:0], er}, 32'h0000_0001);
        for (i = 0; i < 4; i++) begin
            apb(1, OFS_CTRL, 32'(1 + 2 * i));
            @(negedge clk_sys_i);
            chk(pedestal_o, (i == 3) ? 32'h0000_0002 : 32'(i));
        end
        apb(1, OFS_CTRL, 32'h0000_0003);
        // All sixteen control combinations
        for (i = 0; i < 16; i++) begin
            px(8'(8'h3C ^ (i * 8'h11)), 4'(i));
            repeat (3) @(posedge clk_sys_i);
        end
        drain();
        // Converter stalls until the source is refused
        dac_ready_i <= 1'b0;
        fork
            for (int j = 0; j < 4; j++) px(8'(j + 1), 4'hF);
            begin
                repeat (8) @(posedge clk_sys_i);
                @(negedge clk_sys_i);
                chk(pix_ready_o, 0);
                apb(0, OFS_STATUS, 0);
                chk(rd, 32'h0000_0007);
                dac_ready_i <= 1'b1;
            end
        join
        drain();
        apb(0, OFS_ACCEPT, 0);
        chk(rd, 32'd20);
        // Disabled with counters cleared
        apb(1, OFS_CTRL, 32'h0000_000A);
        en = 1'b0;
        px(8'h81, 4'b1101);
        drain();
        apb(0, OFS_ACCEPT, 0);
        chk(rd, 32'd1);
        apb(0, OFS_STALL, 0);
        chk(rd, 32'd0);
        finish_test();
    end
endmodule
